// ===== logic/ccp_pkg.sv
// Constants shared by the capture/compare/PWM mode control design
package ccp_pkg;
  // Register byte addresses
  localparam logic [7:0] unit_control_addr = 8'h00;
  localparam logic [7:0] timer_pairing_addr = 8'h04;
  localparam logic [7:0] restart_deadband_addr = 8'h08;
  localparam logic [7:0] steering_addr = 8'h0c;
  localparam logic [7:0] shutdown_addr = 8'h10;
  localparam logic [7:0] value_addr = 8'h14;
  localparam logic [7:0] status_addr = 8'h18;
  // Reset values
  localparam logic [7:0] unit_control_rst = 8'h00;
  localparam logic [7:0] timer_pairing_rst = 8'h00;
  localparam logic [7:0] restart_deadband_rst = 8'h00;
  localparam logic [4:0] steering_rst = 5'h01;
  localparam logic [7:0] shutdown_rst = 8'h00;
  // Field positions in the unit control register
  localparam int mode_lsb = 0;
  localparam int duty_lsb = 4;
  localparam int config_lsb = 6;
  // Field positions elsewhere
  localparam int deadband_lsb = 0;
  localparam int sync_bit = 4;
  localparam int irq_bit = 0;
  localparam int adc_bit = 1;
  // Mode codes
  localparam logic [3:0] mode_off = 4'h0;
  localparam logic [3:0] mode_toggle = 4'h2;
  localparam logic [3:0] mode_cap_fall = 4'h4;
  localparam logic [3:0] mode_cap_rise = 4'h5;
  localparam logic [3:0] mode_cap_rise4 = 4'h6;
  localparam logic [3:0] mode_cap_rise16 = 4'h7;
  localparam logic [3:0] mode_set = 4'h8;
  localparam logic [3:0] mode_clear = 4'h9;
  localparam logic [3:0] mode_irq_only = 4'ha;
  localparam logic [3:0] mode_special = 4'hb;
  // Output configuration codes
  localparam logic [1:0] cfg_single = 2'h0;
  localparam logic [1:0] cfg_forward = 2'h1;
  localparam logic [1:0] cfg_half = 2'h2;
  localparam logic [1:0] cfg_reverse = 2'h3;
  // Timing: one delay count is one instruction cycle of four clock periods
  localparam int tosc_per_count = 4;
  localparam int prescale_4 = 4;
  localparam int prescale_16 = 16;
endpackage

// ===== logic/capture_prescaler.sv
// Edge detection and edge-count prescaling for capture events
`timescale 1ns/1ps
module capture_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic [3:0] mode,
  input wire logic pin_in,
  // Event
  output logic event_pulse
);
  logic pin_prev_reg;
  logic [3:0] count_reg;
  logic rise;
  logic fall;
  logic hit;

  assign rise = pin_in && !pin_prev_reg;
  assign fall = !pin_in && pin_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_in;
    end
  end

  // Prescaler counts rising edges; a mode write clears it so no partial count leaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 4'h0;
    end else if (clear) begin
      count_reg <= 4'h0;
    end else if (rise) begin
      count_reg <= count_reg + 4'h1;
    end
  end

  always_comb begin
    case (mode)
      ccp_pkg::mode_cap_fall: hit = fall;
      ccp_pkg::mode_cap_rise: hit = rise;
      ccp_pkg::mode_cap_rise4: hit = rise && (count_reg[1:0] == 2'(ccp_pkg::prescale_4 - 1));
      ccp_pkg::mode_cap_rise16: hit = rise && (count_reg == 4'(ccp_pkg::prescale_16 - 1));
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= hit && !clear;
    end
  end
endmodule

// ===== logic/deadband_delay.sv
// Delays each inactive-to-active edge of a drive signal by a programmed count
`timescale 1ns/1ps
module deadband_delay #(
  parameter int count_width = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and data
  input wire logic [count_width-1:0] delay_count,
  input wire logic drive_in,
  output logic drive_out
);
  localparam int cw = count_width + 2;
  logic [cw-1:0] elapsed_reg;
  logic [cw-1:0] target;

  initial begin
    if (count_width < 1 || count_width > 16) begin
      $error("deadband_delay: count_width out of range");
    end
  end

  // Each count is one instruction cycle of four clock periods
  assign target = cw'(delay_count) * cw'(ccp_pkg::tosc_per_count);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_reg <= '0;
    end else if (!drive_in) begin
      elapsed_reg <= '0;
    end else if (elapsed_reg < target) begin
      elapsed_reg <= elapsed_reg + cw'(1);
    end
  end

  // Turn-off is immediate, turn-on waits out the dead band
  always_comb begin
    drive_out = drive_in && (elapsed_reg >= target);
  end
endmodule

// ===== logic/ccp_mode_control.sv
// Capture/compare/PWM mode control with APB registers and enhanced outputs
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Mode 0000 stops everything and resets state
// - Codes 0001 and 0011 reserved, treated off
// - Mode 0010 toggles pin on match
// - Capture on fall, rise, 4th, 16th rise
// - Mode 1000 sets pin and flag
// - Mode 1001 clears pin, sets flag
// - Mode 1010 sets flag only
// - Mode 1011 flag and resets selected timer
// - Special event also sets converter-on bit
// - Duty is duty byte plus two bits
// - Duty bits ignored outside PWM
// - Half bridge polarity per mode low bits
// - Full bridge pair polarity per mode bits
// - Steering only in PWM single output
// - Timer select picks pair; 11 reserved
// - Dead band delays inactive-to-active edges, half bridge only
module ccp_mode_control #(
  parameter bit full_bridge = 1'b1,
  parameter int deadband_width = 7
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture/compare time bases
  input wire logic [15:0] timer1_count,
  input wire logic [15:0] timer3_count,
  input wire logic [15:0] timer5_count,
  output logic [2:0] timer_reset,
  // PWM time bases, period start pulses
  input wire logic [9:0] pwm2_count,
  input wire logic [9:0] pwm4_count,
  input wire logic [9:0] pwm6_count,
  input wire logic [2:0] period_start,
  // Capture input pin
  input wire logic capture_pin,
  // Converter start
  output logic converter_on_bit,
  // Output pins
  output logic output_a,
  output logic output_b,
  output logic output_c,
  output logic output_d,
  output logic [3:0] output_drive_n
);
  logic [7:0] control_reg;
  logic [7:0] timer_pairing_reg;
  logic [7:0] restart_deadband_reg;
  logic [4:0] steering_reg;
  logic [4:0] steering_live_reg;
  logic [7:0] shutdown_reg;
  logic [15:0] value_reg;
  logic unit_irq_flag_reg;
  logic adc_status_reg;
  logic [9:0] duty_latched_reg;
  logic match_prev_reg;
  logic compare_pin_reg;
  logic pwm_raw_reg;
  logic [3:0] mode;
  logic [1:0] duty_low_bits;
  logic [1:0] output_config_select;
  logic [1:0] timer_pair_select;
  logic [6:0] deadband_count;
  logic wr;
  logic rd;
  logic mapped;
  logic mode_write;
  logic pwm_mode;
  logic compare_mode;
  logic capture_mode;
  logic [15:0] sel_timer;
  logic [9:0] sel_pwm;
  logic sel_start;
  logic match_now;
  logic match_edge;
  logic capture_event;
  logic irq_set;
  logic adc_set;
  logic db_a;
  logic db_b;
  logic [3:0] pin_next;
  logic [3:0] drive_next;
  logic [31:0] read_value;

  initial begin
    if (deadband_width != 7) begin
      $error("ccp_mode_control: deadband_width must be 7");
    end
  end

  // Decodes a two-bit timer selection; the reserved code falls back to the first pair
  function automatic logic [1:0] pair_index(input logic [1:0] sel);
    pair_index = (sel == 2'h3) ? 2'h0 : sel;
  endfunction

  // True when the mode code is one of the compare actions
  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == ccp_pkg::mode_toggle) || (m[3:2] == 2'b10);
  endfunction

  assign mode = control_reg[ccp_pkg::mode_lsb +: 4];
  assign duty_low_bits = control_reg[ccp_pkg::duty_lsb +: 2];
  assign output_config_select = control_reg[ccp_pkg::config_lsb +: 2];
  assign timer_pair_select = timer_pairing_reg[1:0];
  assign deadband_count = restart_deadband_reg[ccp_pkg::deadband_lsb +: 7];

  // APB handshake: one wait state, answer on the second access cycle
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && !pready && !pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ccp_pkg::status_addr);
  assign mode_write = wr && mapped && (paddr == ccp_pkg::unit_control_addr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    case (paddr)
      ccp_pkg::unit_control_addr: read_value = {24'h0, control_reg};
      ccp_pkg::timer_pairing_addr: read_value = {24'h0, timer_pairing_reg};
      ccp_pkg::restart_deadband_addr: read_value = {24'h0, restart_deadband_reg};
      ccp_pkg::steering_addr: read_value = {27'h0, steering_reg};
      ccp_pkg::shutdown_addr: read_value = {24'h0, shutdown_reg};
      ccp_pkg::value_addr: read_value = {16'h0, value_reg};
      ccp_pkg::status_addr: read_value = {30'h0, adc_status_reg, unit_irq_flag_reg};
      default: read_value = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd) begin
      prdata <= read_value;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= ccp_pkg::unit_control_rst;
      timer_pairing_reg <= ccp_pkg::timer_pairing_rst;
      restart_deadband_reg <= ccp_pkg::restart_deadband_rst;
      steering_reg <= ccp_pkg::steering_rst;
      shutdown_reg <= ccp_pkg::shutdown_rst;
    end else if (wr && mapped) begin
      case (paddr)
        ccp_pkg::unit_control_addr: control_reg <= pwdata[7:0];
        ccp_pkg::timer_pairing_addr: timer_pairing_reg <= {6'h0, pwdata[1:0]};
        ccp_pkg::restart_deadband_addr: restart_deadband_reg <= pwdata[7:0];
        ccp_pkg::steering_addr: steering_reg <= pwdata[4:0];
        ccp_pkg::shutdown_addr: shutdown_reg <= pwdata[7:0];
        default: control_reg <= control_reg;
      endcase
    end
  end

  // Mode classes; reserved codes fall into none of them
  assign pwm_mode = (mode[3:2] == 2'b11);
  assign compare_mode = is_compare(mode);
  assign capture_mode = (mode[3:2] == 2'b01);

  // Time base selection
  always_comb begin
    case (pair_index(timer_pair_select))
      2'h1: begin
        sel_timer = timer3_count;
        sel_pwm = pwm4_count;
        sel_start = period_start[1];
      end
      2'h2: begin
        sel_timer = timer5_count;
        sel_pwm = pwm6_count;
        sel_start = period_start[2];
      end
      default: begin
        sel_timer = timer1_count;
        sel_pwm = pwm2_count;
        sel_start = period_start[0];
      end
    endcase
  end

  capture_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(mode_write || !capture_mode),
    .mode(mode),
    .pin_in(capture_pin),
    .event_pulse(capture_event)
  );

  // Act once per match, not for every cycle the timer sits on the value
  assign match_now = compare_mode && (sel_timer == value_reg);
  assign match_edge = match_now && !match_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_reg <= 1'b0;
    end else begin
      match_prev_reg <= match_now;
    end
  end

  // Value register: software write, or capture copy of the selected timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= 16'h0;
    end else if (capture_event && capture_mode) begin
      value_reg <= sel_timer;
    end else if (wr && mapped && paddr == ccp_pkg::value_addr) begin
      value_reg <= pwdata[15:0];
    end
  end

  // Compare pin actions; mode 0000 returns the latch to reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin_reg <= 1'b0;
    end else if (mode == ccp_pkg::mode_off) begin
      compare_pin_reg <= 1'b0;
    end else if (match_edge) begin
      case (mode)
        ccp_pkg::mode_toggle: compare_pin_reg <= !compare_pin_reg;
        ccp_pkg::mode_set: compare_pin_reg <= 1'b1;
        ccp_pkg::mode_clear: compare_pin_reg <= 1'b0;
        default: compare_pin_reg <= compare_pin_reg;
      endcase
    end
  end

  assign irq_set = (match_edge && mode[3]) || (capture_event && capture_mode);
  assign adc_set = match_edge && (mode == ccp_pkg::mode_special);

  // Status flags: write one to clear, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_irq_flag_reg <= 1'b0;
      adc_status_reg <= 1'b0;
    end else begin
      if (irq_set) begin
        unit_irq_flag_reg <= 1'b1;
      end else if (wr && mapped && paddr == ccp_pkg::status_addr && pwdata[ccp_pkg::irq_bit]) begin
        unit_irq_flag_reg <= 1'b0;
      end
      if (adc_set) begin
        adc_status_reg <= 1'b1;
      end else if (wr && mapped && paddr == ccp_pkg::status_addr && pwdata[ccp_pkg::adc_bit]) begin
        adc_status_reg <= 1'b0;
      end
    end
  end

  // Special event trigger pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reset <= 3'h0;
      converter_on_bit <= 1'b0;
    end else begin
      timer_reset <= adc_set ? (3'h1 << pair_index(timer_pair_select)) : 3'h0;
      converter_on_bit <= adc_set;
    end
  end

  // Duty reloads at period start so each period is whole; steering does too only when its sync bit is set, otherwise at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_latched_reg <= 10'h0;
    end else if (!pwm_mode) begin
      duty_latched_reg <= 10'h0;
    end else if (sel_start) begin
      duty_latched_reg <= {value_reg[7:0], duty_low_bits};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steering_live_reg <= ccp_pkg::steering_rst;
    end else if (!steering_reg[ccp_pkg::sync_bit] || sel_start) begin
      steering_live_reg <= steering_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_raw_reg <= 1'b0;
    end else begin
      pwm_raw_reg <= pwm_mode && (sel_pwm < duty_latched_reg);
    end
  end

  deadband_delay #(.count_width(deadband_width)) u_db_a (
    .pclk(pclk),
    .presetn(presetn),
    .delay_count(deadband_count),
    .drive_in(pwm_raw_reg),
    .drive_out(db_a)
  );

  deadband_delay #(.count_width(deadband_width)) u_db_b (
    .pclk(pclk),
    .presetn(presetn),
    .delay_count(deadband_count),
    .drive_in(pwm_mode && !pwm_raw_reg),
    .drive_out(db_b)
  );

  // Active-level pin map before polarity; bit order is d, c, b, a
  always_comb begin
    pin_next = 4'h0;
    drive_next = 4'h0;
    if (pwm_mode) begin
      case (full_bridge ? output_config_select : {output_config_select[1], 1'b0})
        ccp_pkg::cfg_half: begin
          pin_next = {2'b00, db_b, db_a};
          drive_next = 4'h3;
        end
        ccp_pkg::cfg_forward: begin
          pin_next = {pwm_raw_reg, 1'b0, 1'b0, 1'b1};
          drive_next = 4'hf;
        end
        ccp_pkg::cfg_reverse: begin
          pin_next = {1'b0, 1'b1, pwm_raw_reg, 1'b0};
          drive_next = 4'hf;
        end
        default: begin
          pin_next = {4{pwm_raw_reg}};
          drive_next = steering_live_reg[3:0];
        end
      endcase
    end else if (compare_mode) begin
      pin_next = {3'b000, compare_pin_reg};
      drive_next = 4'h1;
    end
  end

  // Polarity: bit 1 inverts A/C, bit 0 inverts B/D
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
      output_c <= 1'b0;
      output_d <= 1'b0;
      output_drive_n <= 4'hf;
    end else begin
      output_a <= pin_next[0] ^ (pwm_mode && mode[1]);
      output_b <= pin_next[1] ^ (pwm_mode && mode[0]);
      output_c <= pin_next[2] ^ (pwm_mode && mode[1]);
      output_d <= pin_next[3] ^ (pwm_mode && mode[0]);
      output_drive_n <= ~drive_next;
    end
  end
endmodule

// ===== tb/ccp_mode_chk.sv
// Checker for bus handshake and special event outputs of the mode control block
`timescale 1ns/1ps
module ccp_mode_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Special event
  input wire logic [2:0] timer_reset,
  input wire logic converter_on_bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  wait_state_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access phase not one wait state");
  bad_addr_a: assert property (pready && (paddr > 8'h18 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped address not refused");
  good_addr_a: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  trig_pulse_a: assert property (timer_reset != 3'h0 |=> timer_reset == 3'h0)
    else $error("timer reset longer than one cycle");
  trig_one_a: assert property ($onehot0(timer_reset))
    else $error("more than one timer reset");
  adc_trig_a: assert property (converter_on_bit == (timer_reset != 3'h0))
    else $error("converter start not with timer reset");
  // Margin of two cycles lets an event launched at the write edge drain
  no_trig_a: assert property (psel && penable && pready && pwrite && paddr == 8'h00 &&
    pwdata[3:0] != 4'hb |-> ##2 (timer_reset == 3'h0) [*8])
    else $error("timer reset outside special event mode");
endmodule
bind ccp_mode_control ccp_mode_chk i_ccp_mode_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_reset, .converter_on_bit);

// ===== tb/time_base_model.sv
// Time base model: compare timers with reset requests and a PWM period counter
`timescale 1ns/1ps
module time_base_model #(
  parameter int wrap = 200,
  parameter int period = 128
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer reset requests
  input wire logic [2:0] timer_reset,
  // Time bases
  output logic [15:0] timer1_count,
  output logic [15:0] timer3_count,
  output logic [15:0] timer5_count,
  output logic [9:0] pwm_count,
  output logic [2:0] period_start
);
  // Short wrap keeps compare matches frequent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_count <= 16'h0000;
      timer3_count <= 16'h0000;
      timer5_count <= 16'h0000;
      pwm_count <= 10'h000;
    end else begin
      timer1_count <= (timer_reset[0] || timer1_count == wrap - 1) ? 16'h0000 : timer1_count + 16'h0001;
      timer3_count <= (timer_reset[1] || timer3_count == wrap - 1) ? 16'h0000 : timer3_count + 16'h0001;
      timer5_count <= (timer_reset[2] || timer5_count == wrap - 1) ? 16'h0000 : timer5_count + 16'h0001;
      pwm_count <= (pwm_count == period - 1) ? 10'h000 : pwm_count + 10'h001;
    end
  end
  // All three PWM bases share one period
  assign period_start = {3{pwm_count == 10'h000}};
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the capture/compare/PWM mode control block
`timescale 1ns/1ps
module tb_top;
  localparam int period = 128;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic capture_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, converter_on_bit, output_a, output_b, output_c, output_d;
  logic [2:0] timer_reset, period_start;
  logic [3:0] output_drive_n;
  logic [15:0] timer1_count, timer3_count, timer5_count;
  logic [9:0] pwm_count;
  int errors = 0;
  int checks = 0;
  int tr0 = 0;
  int tr1 = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    if (timer_reset[0] === 1'b1) tr0++;
    if (timer_reset[1] === 1'b1) tr1++;
  end
  time_base_model #(.wrap(200), .period(period)) i_time_base_model (.pclk, .presetn,
    .timer_reset, .timer1_count, .timer3_count, .timer5_count, .pwm_count, .period_start);
  ccp_mode_control i_ccp_mode_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer1_count, .timer3_count, .timer5_count,
    .timer_reset, .pwm2_count(pwm_count), .pwm4_count(pwm_count), .pwm6_count(pwm_count),
    .period_start, .capture_pin, .converter_on_bit, .output_a, .output_b, .output_c,
    .output_d, .output_drive_n);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  // Polls the flag; a match comes at least once per timer wrap
  task automatic wait_irq;
    logic [31:0] r;
    int n;
    r = 32'h0;
    n = 0;
    while (r[0] !== 1'b1 && n < 80) begin
      rd(ccp_pkg::status_addr, r);
      n++;
    end
    chk("irq flag", 32'h1, {31'h0, r[0]});
  endtask
  task automatic test_reset;
    logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    logic [31:0] r;
    logic e;
    chk("drive_n", 32'hf, {28'h0, output_drive_n});
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], r);
      chk("reset value", rv[i], r);
    end
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("test reset done");
  endtask
  task automatic test_compare;
    logic [3:0] md [4] = '{4'h8, 4'h9, 4'ha, 4'h2};
    logic pin [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    wr(ccp_pkg::value_addr, 32'd50);
    for (int i = 0; i < 4; i++) begin
      wr(ccp_pkg::status_addr, 32'h3);
      wr(ccp_pkg::unit_control_addr, {26'h0, 2'h3, md[i]});
      // Toggle raises no flag, so its match is judged by the pin alone
      if (md[i][3]) begin
        wait_irq;
      end else begin
        for (int n = 0; n < 250 && output_a !== 1'b1; n++) @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      chk("compare pin", {31'h0, pin[i]}, {31'h0, output_a});
    end
    $display("test compare done");
  endtask
  task automatic test_special;
    logic [31:0] r;
    wr(ccp_pkg::timer_pairing_addr, 32'h1);
    wr(ccp_pkg::status_addr, 32'h3);
    wr(ccp_pkg::unit_control_addr, 32'hb);
    wait_irq;
    repeat (3) @(posedge pclk);
    rd(ccp_pkg::status_addr, r);
    chk("status", 32'h3, r);
    chk("timer3 reset", 32'h1, {31'h0, tr1 != 0});
    chk("timer1 reset", 32'h0, tr0);
    wr(ccp_pkg::unit_control_addr, 32'h0);
    repeat (4) @(posedge pclk);
    chk("pins off", 32'h0, {28'h0, output_a, output_b, output_c, output_d});
    $display("test special done");
  endtask
  task automatic test_capture;
    logic [3:0] md [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int edges [4] = '{1, 1, 4, 16};
    logic [31:0] r;
    wr(ccp_pkg::timer_pairing_addr, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ccp_pkg::status_addr, 32'h3);
      wr(ccp_pkg::unit_control_addr, {28'h0, md[i]});
      repeat (edges[i]) begin
        rd(ccp_pkg::status_addr, r);
        chk("early capture", 32'h0, r & 32'h1);
        capture_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        capture_pin <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      rd(ccp_pkg::status_addr, r);
      chk("capture flag", 32'h1, r & 32'h1);
    end
    $display("test capture done");
  endtask
  task automatic pwm_case(input logic [7:0] ctl, input int ea, input int eb, input int ed);
    int na;
    int nb;
    int nd;
    na = 0;
    nb = 0;
    nd = 0;
    wr(ccp_pkg::unit_control_addr, {24'h0, ctl});
    repeat (2 * period + 4) @(posedge pclk);
    repeat (period) begin
      @(posedge pclk);
      na += int'(output_a === 1'b1);
      nb += int'(output_b === 1'b1);
      nd += int'(output_d === 1'b1);
    end
    chk("pwm a high", ea, na);
    if (eb >= 0) chk("pwm b high", eb, nb);
    if (ed >= 0) chk("pwm d high", ed, nd);
  endtask
  task automatic test_pwm;
    int db;
    db = 64 - 2 * ccp_pkg::tosc_per_count;
    wr(ccp_pkg::value_addr, 32'h10);
    pwm_case(8'h3c, 67, -1, -1);
    chk("drive a", 32'h0, {31'h0, output_drive_n[0]});
    pwm_case(8'h3f, period - 67, -1, -1);
    pwm_case(8'h4c, period, 0, 64);
    pwm_case(8'h4e, 0, 0, 64);
    pwm_case(8'hcc, 0, 64, 0);
    wr(ccp_pkg::restart_deadband_addr, 32'h2);
    pwm_case(8'h8c, db, db, 0);
    $display("test pwm done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset;
    test_compare;
    test_special;
    test_capture;
    test_pwm;
    wrap_up;
  end
  // Whole run needs well under a tenth of this span
  initial begin
    #1000000;
    errors++;
    $display("ERROR watchdog expected done seen timeout");
    wrap_up;
  end
endmodule
